// [include/crs_map.svh]
// Register offsets, field positions, reset values and timing counts of the clock/reset sequencer
`ifndef CRS_MAP_SVH
`define CRS_MAP_SVH
`define CRS_OFF_MAIN_CLOCK_CTRL_STATUS 8'h00
`define CRS_OFF_RC_TRIM 8'h04
`define CRS_OFF_OPTIONS 8'h08
`define CRS_OFF_SYSTEM_INTEGRITY_STATUS 8'h0C
`define CRS_MCCS_RESET 8'h00
`define CRS_TRIM_RESET 8'hFF
`define CRS_BIT_SLOW_SELECT 0
`define CRS_BIT_CLOCK_OUTPUT_ENABLE 1
`define CRS_BIT_LOCKED 3
`define CRS_SLOW_DIV 32
`define CRS_DELAY_SHORT 256
`define CRS_DELAY_LONG 4096
`define CRS_FETCH_CYCLES 2
`define CRS_VECTOR_ADDR 16'hFFFE
`define CRS_PLL_START_NS 32000
`define CRS_CLK_PERIOD_NS 8
`endif

// [include/crs_pkg.sv]
// Types of the clock/reset sequencer
package crs_pkg;
    typedef enum logic [1:0] {
        CRS_SRC_EXT,
        CRS_SRC_XTAL,
        CRS_SRC_RC
    } crs_source_type;
    typedef enum logic [2:0] {
        CRS_ACTIVE,
        CRS_DELAY,
        CRS_PLL_WAIT,
        CRS_FETCH,
        CRS_RUN
    } crs_phase_type;
endpackage

// [verilog/crs_clock_reset.sv]
// Clock selection, slow divider, trim register and reset sequencer with AXI4-Lite access
// How it works
// - Every reset restores the trim register to FFh.
// - Trim code drives RC frequency: 00h fastest, FFh slowest.
// - PLL multiplies 1 MHz by 4 or 8 per two option bits.
// - Without PLL: RC output if RC enabled, else external clock.
// - PLL withholds its output for the start delay on every start.
// - Lock bit sets once PLL output reaches operating frequency.
// - Clock output enable bit 1, reset clear; 1 drives clock out.
// - Slow select bit 0, reset clear; 1 divides CPU clock by 32.
// - Timer multiplier takes 8 MHz input times four.
// - Pin, low-voltage, watchdog sources; pin held low during delay.
// - Sequence: active phase, fixed delay, then vector fetch.
// - Delay 256 cycles for RC or external, 4096 for crystal.
// - Vector fetch lasts two cycles from FFFEh and FFFFh.
// - With PLL enabled, PLL start delay adds after reset delay.
// - Reset pin is open drain, also driven low externally.
// - External reset is caught asynchronously, without clock.
// - Crystal oscillator keeps running through reset.
// - Clock source fixed by non-volatile options, not registers.
// - Unused multi-oscillator means default port pin is external clock.
// - Lock flag is bit 3 of status, hardware-only.
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "crs_map.svh"
module crs_clock_reset #(
    parameter int DELAY_LONG = `CRS_DELAY_LONG,
    parameter int PLL_START_CYCLES = (`CRS_PLL_START_NS + `CRS_CLK_PERIOD_NS - 1)
        / `CRS_CLK_PERIOD_NS
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [1:0] optSource,
    input wire logic optPllEnable,
    input wire logic optPllTimes8,
    input wire logic optMultiOscUsed,
    input wire logic oscInPin,
    input wire logic defaultExtClockPin,
    input wire logic rcClock,
    input wire logic pllLockRaw,
    input wire logic resetPinIn,
    input wire logic lowVoltageReset,
    input wire logic watchdogReset,
    output logic resetPinOut,
    output logic resetPinOe,
    output logic cpuReset,
    output logic vectorFetch,
    output logic [15:0] vectorAddr,
    output logic cpuClockEnable,
    output logic clockOutputPin,
    output logic clockOutputActive,
    output logic pllEnable,
    output logic pllTimes8,
    output logic timerPllEnable,
    output logic timerInputHalve,
    output logic [7:0] trimValue,
    output logic xtalRun,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int CNT_W = 16;
    localparam int DIV_W = $clog2(`CRS_SLOW_DIV);

    crs_pkg::crs_phase_type phase;
    logic [CNT_W-1:0] count;
    logic [7:0] mainClockCtrlStatus;
    logic [7:0] rcTrim;
    logic locked;
    logic [DIV_W-1:0] slowCount;
    logic slowActive;
    logic [1:0] pinSync, lvSync, wdSync, lockSync, oscSync, extSync, rcSync;
    logic anySource;
    logic rstSeq_n;
    logic [CNT_W-1:0] delayLast;
    logic oscClockSample;
    logic awTaken, wTaken;
    logic [7:0] awIdx, arIdx;

    // Pin reset clears the sequencer without a clock; the release is synchronised
    // Own pull-down is ignored, else the device would hold itself in reset
    assign anySource = !rst_n || (!resetPinIn && resetPinOe)
        || lowVoltageReset || watchdogReset;
    always_ff @(posedge sys_clk or posedge anySource) begin
        if (anySource)
            pinSync <= 2'b00;
        else
            pinSync <= {pinSync[0], 1'b1};
    end
    assign rstSeq_n = rst_n && pinSync[1];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lvSync <= 2'b00;
            wdSync <= 2'b00;
            lockSync <= 2'b00;
            oscSync <= 2'b00;
            extSync <= 2'b00;
            rcSync <= 2'b00;
        end else begin
            lvSync <= {lvSync[0], lowVoltageReset};
            wdSync <= {wdSync[0], watchdogReset};
            lockSync <= {lockSync[0], pllLockRaw};
            oscSync <= {oscSync[0], oscInPin};
            extSync <= {extSync[0], defaultExtClockPin};
            rcSync <= {rcSync[0], rcClock};
        end
    end

    // Delay length depends only on the option-fixed source
    assign delayLast = (optSource == crs_pkg::CRS_SRC_XTAL) ?
        CNT_W'(DELAY_LONG - 1) : CNT_W'(`CRS_DELAY_SHORT - 1);

    always_ff @(posedge sys_clk or negedge rstSeq_n) begin
        if (!rstSeq_n) begin
            phase <= crs_pkg::CRS_ACTIVE;
            count <= '0;
        end else if (lvSync[1] || wdSync[1]) begin
            phase <= crs_pkg::CRS_ACTIVE;
            count <= '0;
        end else begin
            unique case (phase)
                crs_pkg::CRS_ACTIVE: begin
                    phase <= crs_pkg::CRS_DELAY;
                    count <= '0;
                end
                crs_pkg::CRS_DELAY: begin
                    if (count == delayLast) begin
                        phase <= optPllEnable ? crs_pkg::CRS_PLL_WAIT
                            : crs_pkg::CRS_FETCH;
                        count <= '0;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
                crs_pkg::CRS_PLL_WAIT: begin
                    if (count == CNT_W'(PLL_START_CYCLES - 1)) begin
                        phase <= crs_pkg::CRS_FETCH;
                        count <= '0;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
                crs_pkg::CRS_FETCH: begin
                    if (count == CNT_W'(`CRS_FETCH_CYCLES - 1)) begin
                        phase <= crs_pkg::CRS_RUN;
                        count <= '0;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
                crs_pkg::CRS_RUN: begin
                    count <= '0;
                end
            endcase
        end
    end

    // Open drain: enable low means pin pulled low
    assign resetPinOut = 1'b0;
    assign resetPinOe = !(phase == crs_pkg::CRS_ACTIVE
        || phase == crs_pkg::CRS_DELAY);
    assign cpuReset = (phase != crs_pkg::CRS_RUN) && (phase != crs_pkg::CRS_FETCH);
    assign vectorFetch = (phase == crs_pkg::CRS_FETCH);
    assign vectorAddr = `CRS_VECTOR_ADDR | 16'(count[0]);
    assign xtalRun = (optSource == crs_pkg::CRS_SRC_XTAL);
    assign pllEnable = optPllEnable && (optSource != crs_pkg::CRS_SRC_XTAL);
    assign pllTimes8 = optPllTimes8;
    // 8 MHz only from RC x8 or a halved 16 MHz clock
    assign timerPllEnable = (pllEnable && optPllTimes8)
        || optSource == crs_pkg::CRS_SRC_XTAL
        || (optSource == crs_pkg::CRS_SRC_EXT && !optPllEnable);
    assign timerInputHalve = !pllEnable;
    assign trimValue = rcTrim;

    // Oscillator clock seen as a sampled level for the output pin
    always_comb begin
        if (optSource == crs_pkg::CRS_SRC_RC)
            oscClockSample = rcSync[1];
        else if (optMultiOscUsed)
            oscClockSample = oscSync[1];
        else
            oscClockSample = extSync[1];
    end

    // Lock flag, withheld until the sequence reaches run
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            locked <= 1'b0;
        else
            locked <= pllEnable && lockSync[1]
                && phase == crs_pkg::CRS_RUN;
    end

    // Enter slow mode at once, leave it only at the end of a full slow period, so no short pulse appears
    always_ff @(posedge sys_clk or negedge rstSeq_n) begin
        if (!rstSeq_n) begin
            slowCount <= '0;
            slowActive <= 1'b0;
        end else begin
            slowCount <= slowActive ? slowCount + 1'b1 : '0;
            if (!slowActive || slowCount == DIV_W'(`CRS_SLOW_DIV - 1))
                slowActive <= mainClockCtrlStatus[`CRS_BIT_SLOW_SELECT];
        end
    end
    assign cpuClockEnable = !slowActive || slowCount == '0;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            clockOutputPin <= 1'b0;
        else
            clockOutputPin <= mainClockCtrlStatus[`CRS_BIT_CLOCK_OUTPUT_ENABLE]
                && oscClockSample;
    end
    assign clockOutputActive = mainClockCtrlStatus[`CRS_BIT_CLOCK_OUTPUT_ENABLE];

    // AXI4-Lite write channel
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            awTaken <= 1'b0;
            wTaken <= 1'b0;
            awIdx <= '0;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awTaken <= 1'b1;
                awIdx <= s_axi_awaddr[7:0];
            end
            if (s_axi_wvalid && s_axi_wready)
                wTaken <= 1'b1;
            if (awTaken && wTaken) begin
                awTaken <= 1'b0;
                wTaken <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end
    assign s_axi_awready = !awTaken && !s_axi_bvalid;
    assign s_axi_wready = !wTaken && !s_axi_bvalid;
    assign s_axi_bresp = (awIdx == `CRS_OFF_MAIN_CLOCK_CTRL_STATUS
        || awIdx == `CRS_OFF_RC_TRIM) ? 2'h0 : 2'h2;

    logic [31:0] wdataHeld;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            wdataHeld <= '0;
        else if (s_axi_wvalid && s_axi_wready)
            wdataHeld <= {s_axi_wstrb[0] ? 24'h000000 : 24'h000000,
                s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00};
    end

    logic strbHeld;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            strbHeld <= 1'b0;
        else if (s_axi_wvalid && s_axi_wready)
            strbHeld <= s_axi_wstrb[0];
    end

    // Registers reset on every reset source through the sequencer reset
    always_ff @(posedge sys_clk or negedge rstSeq_n) begin
        if (!rstSeq_n) begin
            mainClockCtrlStatus <= `CRS_MCCS_RESET;
            rcTrim <= `CRS_TRIM_RESET;
        end else if (lvSync[1] || wdSync[1]) begin
            mainClockCtrlStatus <= `CRS_MCCS_RESET;
            rcTrim <= `CRS_TRIM_RESET;
        end else if (awTaken && wTaken && strbHeld) begin
            if (awIdx == `CRS_OFF_MAIN_CLOCK_CTRL_STATUS)
                mainClockCtrlStatus <= {6'h00, wdataHeld[1:0]};
            if (awIdx == `CRS_OFF_RC_TRIM)
                rcTrim <= wdataHeld[7:0];
        end
    end

    // AXI4-Lite read channel
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            arIdx <= '0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            arIdx <= s_axi_araddr[7:0];
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_arready = !s_axi_rvalid;
    always_comb begin
        unique case (arIdx)
            `CRS_OFF_MAIN_CLOCK_CTRL_STATUS: s_axi_rdata = {24'h000000, mainClockCtrlStatus};
            `CRS_OFF_RC_TRIM: s_axi_rdata = {24'h000000, rcTrim};
            `CRS_OFF_OPTIONS: s_axi_rdata = {27'h0000000, optMultiOscUsed, optPllTimes8,
                optPllEnable, optSource};
            `CRS_OFF_SYSTEM_INTEGRITY_STATUS: s_axi_rdata = 32'(locked) << `CRS_BIT_LOCKED;
            default: s_axi_rdata = 32'h00000000;
        endcase
    end
    assign s_axi_rresp = (arIdx[7:4] == 4'h0 && arIdx[1:0] == 2'h0) ? 2'h0 : 2'h2;

    // Checks
    sequence seqDelayDone;
        phase == crs_pkg::CRS_DELAY && count == delayLast;
    endsequence
    chk_pin_low_delay: assert property (@(posedge sys_clk) disable iff (!rstSeq_n)
        phase == crs_pkg::CRS_DELAY |-> !resetPinOe)
        else $error("reset pin released during delay");
    chk_delay_to_next: assert property (@(posedge sys_clk) disable iff (!rstSeq_n || lvSync[1] || wdSync[1])
        seqDelayDone ##1 1 |-> phase == (optPllEnable ? crs_pkg::CRS_PLL_WAIT : crs_pkg::CRS_FETCH))
        else $error("delay did not end in the right phase");
    chk_fetch_two: assert property (@(posedge sys_clk) disable iff (!rstSeq_n || lvSync[1] || wdSync[1])
        $rose(vectorFetch) |-> vectorFetch ##1 vectorFetch ##1 !vectorFetch)
        else $error("vector fetch not two cycles");
    chk_fetch_addr: assert property (@(posedge sys_clk) disable iff (!rstSeq_n)
        $rose(vectorFetch) |-> vectorAddr == 16'hFFFE ##1 vectorAddr == 16'hFFFF)
        else $error("vector address wrong");
    chk_active_first: assert property (@(posedge sys_clk) disable iff (!rstSeq_n || lvSync[1] || wdSync[1])
        phase == crs_pkg::CRS_ACTIVE |=> phase == crs_pkg::CRS_DELAY && count == '0)
        else $error("active phase not followed by delay");
    chk_short_delay: assert property (@(posedge sys_clk) disable iff (!rstSeq_n)
        phase == crs_pkg::CRS_DELAY && optSource != crs_pkg::CRS_SRC_XTAL
        |-> count <= CNT_W'(255))
        else $error("short delay not 256");
    chk_trim_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
        phase == crs_pkg::CRS_ACTIVE |=> rcTrim == 8'hFF)
        else $error("trim not restored after reset");
    chk_lock_bit: assert property (@(posedge sys_clk) disable iff (!rst_n)
        locked |-> pllEnable && phase != crs_pkg::CRS_PLL_WAIT)
        else $error("lock set without pll running");
    chk_slow_period: assert property (@(posedge sys_clk) disable iff (!rstSeq_n)
        slowActive && cpuClockEnable |=> !cpuClockEnable [*8])
        else $error("slow clock enable too frequent");
    chk_mcc_upper: assert property (@(posedge sys_clk) disable iff (!rstSeq_n)
        mainClockCtrlStatus[7:2] == 6'h00)
        else $error("reserved clock bits set");
endmodule // crs_clock_reset

// [verification/crs_board_model.sv]
// Board side model: oscillators, PLL lock and the reset pin wire
`timescale 1ns/1ps
module crs_board_model (
    input wire logic sys_clk,
    input wire logic pllEnable,
    input wire logic resetPinOut,
    input wire logic resetPinOe,
    input wire logic pullLow,
    output logic resetPinIn,
    output logic oscInPin,
    output logic defaultExtClockPin,
    output logic rcClock,
    output logic pllLockRaw
);
    int lockCount = 0;
    initial begin
        oscInPin = 1'b0;
        defaultExtClockPin = 1'b0;
        rcClock = 1'b0;
    end
    // Crystal keeps running through reset, never gated by the device
    always #20 oscInPin = ~oscInPin;
    always #31 defaultExtClockPin = ~defaultExtClockPin;
    always #500 rcClock = ~rcClock;
    // Lock comes 16 cycles after enable, while the bench still holds reset for 20 cycles
    always @(posedge sys_clk) begin
        if (!pllEnable) begin
            lockCount <= 0;
        end else if (lockCount < 16) begin
            lockCount <= lockCount + 1;
        end
    end
    assign pllLockRaw = (lockCount == 16);
    // Open drain with pull-up; either party may pull the wire low
    assign resetPinIn = pullLow ? 1'b0 : (resetPinOe ? 1'b1 : resetPinOut);
endmodule // crs_board_model

// [verification/crs_clock_reset_bench.sv]
// Self-checking bench of the clock and reset sequencer
`timescale 1ns/1ps
module crs_clock_reset_bench;
    typedef struct {
        logic [31:0] addr;
        logic [31:0] data;
        logic [31:0] expData;
        logic [1:0] expResp;
    } crs_row_type;
    // Short counts keep the run brief; expectations derive from them
    localparam int DelayLong = 16;
    localparam int PllStart = 8;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] optSource = 2'h2;
    logic optPllEnable = 1'b0, optPllTimes8 = 1'b1, optMultiOscUsed = 1'b0;
    logic lowVoltageReset = 1'b0, watchdogReset = 1'b0, pullLow = 1'b0;
    logic oscInPin, defaultExtClockPin, rcClock, pllLockRaw, resetPinIn;
    logic resetPinOut, resetPinOe, cpuReset, vectorFetch, cpuClockEnable, xtalRun;
    logic clockOutputPin, clockOutputActive, pllEnable, pllTimes8, timerPllEnable, timerInputHalve;
    logic [15:0] vectorAddr;
    logic [7:0] trimValue;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] rd;
    int failures = 0, compares = 0;
    int nOeR, nVfR, nOeX, nVfX, nOeP, nVfP, en, tg, i;
    crs_row_type rows [6] = '{
        '{32'h0, 32'hFF, 32'h3, 2'h0},
        '{32'h0, 32'h0, 32'h0, 2'h0},
        '{32'h4, 32'h80, 32'h80, 2'h0},
        '{32'h4, 32'h0, 32'h0, 2'h0},
        '{32'h4, 32'hA5, 32'hA5, 2'h0},
        '{32'h10, 32'h5A, 32'h0, 2'h2}};
    always #4 sys_clk = ~sys_clk;
    crs_clock_reset #(.DELAY_LONG(DelayLong), .PLL_START_CYCLES(PllStart)) uut (
        .sys_clk, .rst_n, .optSource, .optPllEnable, .optPllTimes8, .optMultiOscUsed,
        .oscInPin, .defaultExtClockPin, .rcClock, .pllLockRaw, .resetPinIn,
        .lowVoltageReset, .watchdogReset, .resetPinOut, .resetPinOe, .cpuReset,
        .vectorFetch, .vectorAddr, .cpuClockEnable, .clockOutputPin, .clockOutputActive,
        .pllEnable, .pllTimes8, .timerPllEnable, .timerInputHalve, .trimValue, .xtalRun,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    crs_board_model board (.sys_clk, .pllEnable, .resetPinOut, .resetPinOe, .pullLow,
        .resetPinIn, .oscInPin, .defaultExtClockPin, .rcClock, .pllLockRaw);
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("Compares %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic guard(input int n);
        if (n >= 8000) begin
            failures++;
            $display("unexpected wait: expected answer, seen timeout");
            end_of_test();
        end
    endtask
    task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        logic aw, w, b;
        @(posedge sys_clk);
        n = 0;
        aw = 1'b1;
        w = 1'b1;
        b = 1'b0;
        r = 2'h3;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b && n < 8000) begin
            @(posedge sys_clk);
            n++;
            if (aw && s_axi_awready === 1'b1) begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready === 1'b1) begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid === 1'b1) begin
                b = 1'b1;
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end
        end
        guard(n);
    endtask
    task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        logic ar, b;
        @(posedge sys_clk);
        n = 0;
        ar = 1'b1;
        b = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!b && n < 8000) begin
            @(posedge sys_clk);
            n++;
            if (ar && s_axi_arready === 1'b1) begin
                ar = 1'b0;
                s_axi_arvalid <= 1'b0;
            end
            if (s_axi_rvalid === 1'b1) begin
                b = 1'b1;
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
            end
        end
        guard(n);
    endtask
    // Options only change while reset is held, as they are static fuses
    task automatic do_reset(input logic [1:0] src, input logic pll, output int nOe, output int nVf);
        int n;
        @(posedge sys_clk);
        rst_n <= 1'b0;
        optSource <= src;
        optPllEnable <= pll;
        repeat (20) @(posedge sys_clk);
        check("xtalRun", xtalRun, src == 2'h1);
        rst_n <= 1'b1;
        nOe = 0;
        n = 0;
        while (vectorFetch !== 1'b1 && n < 8000) begin
            @(posedge sys_clk);
            n++;
            nOe += (resetPinOe === 1'b0);
        end
        guard(n);
        nVf = n;
        check("vectorAddr", vectorAddr, 16'hFFFE);
        @(posedge sys_clk);
        check("vectorAddr", vectorAddr, 16'hFFFF);
        @(posedge sys_clk);
        check("vectorFetch", vectorFetch, 1'b0);
        check("cpuReset", cpuReset, 1'b0);
    endtask
    task automatic wait_run();
        int n;
        n = 0;
        while (cpuReset !== 1'b0 && n < 8000) begin
            @(posedge sys_clk);
            n++;
        end
        guard(n);
    endtask
    task automatic sample(input int len, output int e, output int t);
        logic prev;
        e = 0;
        t = 0;
        prev = clockOutputPin;
        repeat (len) begin
            @(posedge sys_clk);
            e += (cpuClockEnable === 1'b1);
            t += (clockOutputPin !== prev);
            prev = clockOutputPin;
        end
    endtask
    initial begin
        do_reset(2'h2, 1'b1, nOeP, nVfP);
        check("pllEnable", pllEnable, 1'b1);
        check("pllTimes8", pllTimes8, 1'b1);
        repeat (40) @(posedge sys_clk);
        axi_read(32'hC, rd, rsp);
        check("locked", rd[3], 1'b1);
        do_reset(2'h1, 1'b0, nOeX, nVfX);
        do_reset(2'h2, 1'b0, nOeR, nVfR);
        check("pllEnable", pllEnable, 1'b0);
        check("fetch delay", nVfR - nVfX, 256 - DelayLong);
        check("pin delay", nOeR - nOeX, 256 - DelayLong);
        check("pll wait", nVfP - nVfR, PllStart);
        axi_read(32'hC, rd, rsp);
        check("unlocked", rd[3], 1'b0);
        $display("test reset sequence done");
        axi_read(32'h0, rd, rsp);
        check("main clock reset", rd, 32'h0);
        axi_read(32'h4, rd, rsp);
        check("trim reset", rd, 32'hFF);
        for (i = 0; i < 6; i++) begin
            axi_write(rows[i].addr, rows[i].data, rsp);
            check("bresp", rsp, rows[i].expResp);
            axi_read(rows[i].addr, rd, rsp);
            check("rresp", rsp, rows[i].expResp);
            if (rows[i].expResp == 2'h0) begin
                check("rdata", rd, rows[i].expData);
            end
        end
        check("trimValue", trimValue, 8'hA5);
        $display("test registers done");
        axi_write(32'h0, 32'h1, rsp);
        sample(64, en, tg);
        sample(64, en, tg);
        check("slow enables", en, 2);
        check("clock out idle", tg, 0);
        axi_write(32'h0, 32'h2, rsp);
        check("clockOutputActive", clockOutputActive, 1'b1);
        sample(64, en, tg);
        sample(300, en, tg);
        check("normal enables", en, 300);
        check("clock out running", tg > 0, 1'b1);
        $display("test clocks done");
        axi_write(32'h4, 32'h55, rsp);
        @(posedge sys_clk);
        pullLow <= 1'b1;
        #1;
        check("cpuReset async", cpuReset, 1'b1);
        repeat (3) @(posedge sys_clk);
        pullLow <= 1'b0;
        wait_run();
        check("trim after pin", trimValue, 8'hFF);
        check("clock out cleared", clockOutputActive, 1'b0);
        for (i = 0; i < 2; i++) begin
            axi_write(32'h4, 32'h33, rsp);
            @(posedge sys_clk);
            lowVoltageReset <= (i == 0);
            watchdogReset <= (i == 1);
            repeat (3) @(posedge sys_clk);
            check("resetPinOe", resetPinOe, 1'b0);
            lowVoltageReset <= 1'b0;
            watchdogReset <= 1'b0;
            wait_run();
            check("trim after source", trimValue, 8'hFF);
        end
        do_reset(2'h0, 1'b0, nOeX, nVfX);
        check("timerPllEnable", timerPllEnable, 1'b1);
        check("timerInputHalve", timerInputHalve, 1'b1);
        axi_write(32'h0, 32'h2, rsp);
        sample(300, en, tg);
        check("ext clock out", tg > 0, 1'b1);
        $display("test reset sources done");
        end_of_test();
    end
endmodule // crs_clock_reset_bench
